// *** logic/mopcu_top.sv ***
// Purpose: execution unit for multiply, OR and byte pattern-compare instructions
// Assumes: issue is a one-cycle pulse with a decoded instruction word and operand values
// Notes:   result and writeEnable come out of flip-flops; busy stalls issue
//
// Overview of operation
// - mul writes low word of full 64-bit product.
// - mulh writes high word of signed by signed product.
// - mulhu writes high word of unsigned by unsigned product.
// - mulhsu writes high word of signed first by unsigned second product.
// - register multiplies share an opcode; bits 30,31 pick variant, zero is mul.
// - multiplies finish in one cycle, or three in area-optimised build 1.
// - mul and muli exist only when hardware multiplier setting above zero.
// - high-word multiplies exist only with multiplier setting 2.
// - muli multiplies first operand by sign-extended immediate, low word kept.
// - immediate sign-extends 16 bits unless prefix supplies the upper half.
// - or writes bitwise OR of the two registers in one cycle.
// - ori writes OR of register and extended immediate in one cycle.
// - or naming register zero still writes the OR result like any other.
// - byte-find returns first equal byte pair, 1 at MSB to 4 at LSB.
// - byte-find returns zero when no byte pair matches.
// - equality compare writes 1 when equal else 0, one cycle.
// - inequality compare writes 0 when equal else 1, one cycle.
// - pattern compares exist only when pattern compare enable is 1.
module mopcu_top #(
	parameter int area_optimise_setting       = 0,
	parameter int hardware_multiplier_setting = 2,
	parameter int pattern_compare_enable      = 1
) (
	input  wire logic                         clk,
	input  wire logic                         rst_b,
	input  wire logic                         issue,
	input  wire logic [mopcu_pkg::DATA_W-1:0] instrWord,
	input  wire logic [mopcu_pkg::DATA_W-1:0] first_source_register,
	input  wire logic [mopcu_pkg::DATA_W-1:0] second_source_register,
	input  wire logic                         prefixValid,
	input  wire logic [mopcu_pkg::IMM_W-1:0]  prefixUpper,
	output logic                              resultValid,
	output logic                              writeEnable,
	output logic [mopcu_pkg::REG_W-1:0]       destReg,
	output logic [mopcu_pkg::DATA_W-1:0]      result,
	output logic                              illegalInstr,
	output logic                              busy
);
	import mopcu_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// decode helpers

	// instruction bit n sits at word bit 31-n
	function automatic mopcu_op_t decodeOp(input logic [DATA_W-1:0] w);
		logic [OPC_W-1:0]  opc;
		logic [FUNC_W-1:0] fn;
		opc = w[31:26];
		fn = w[10:0];
		decodeOp = OP_NONE;
		if (opc == OPC_MULI) begin
			decodeOp = OP_MULI;
		end else if (opc == OPC_ORI) begin
			decodeOp = OP_ORI;
		end else if (opc == OPC_MUL) begin
			unique case (fn)
				FN_MUL:    decodeOp = OP_MUL;
				FN_MULH:   decodeOp = OP_MULH;
				FN_MULHU:  decodeOp = OP_MULHU;
				FN_MULHSU: decodeOp = OP_MULHSU;
				default:   decodeOp = OP_NONE;
			endcase
		end else if (opc == OPC_OR && fn == FN_OR) begin
			decodeOp = OP_OR;
		end else if (opc == OPC_PCMPBF && fn == FN_PCMP) begin
			decodeOp = OP_PCMPBF;
		end else if (opc == OPC_PCMPEQ && fn == FN_PCMP) begin
			decodeOp = OP_PCMPEQ;
		end else if (opc == OPC_PCMPNE && fn == FN_PCMP) begin
			decodeOp = OP_PCMPNE;
		end
	endfunction

	function automatic logic isMul(input mopcu_op_t op);
		isMul = (op == OP_MUL) || (op == OP_MULH) || (op == OP_MULHU)
			|| (op == OP_MULHSU) || (op == OP_MULI);
	endfunction

	// build-time availability of each operation
	function automatic logic isBuilt(input mopcu_op_t op);
		unique case (op)
			OP_MUL, OP_MULI:               isBuilt = hardware_multiplier_setting > 0;
			OP_MULH, OP_MULHU, OP_MULHSU:  isBuilt = hardware_multiplier_setting == HWMUL_WIDE;
			OP_PCMPBF, OP_PCMPEQ, OP_PCMPNE: isBuilt = pattern_compare_enable == 1;
			OP_OR, OP_ORI:                 isBuilt = 1'b1;
			default:                       isBuilt = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// operand forming

	mopcu_op_t         curOp;
	logic [DATA_W-1:0] immOperand;
	logic [DATA_W-1:0] opBsel;
	logic [2:0]        bytePos;
	logic [3:0]        byteEq;

	always_comb begin
		curOp = decodeOp(instrWord);
		if (prefixValid) begin
			immOperand = {prefixUpper, instrWord[IMM_W-1:0]};
		end else begin
			immOperand = {{(DATA_W-IMM_W){instrWord[IMM_W-1]}}, instrWord[IMM_W-1:0]};
		end
		opBsel = (curOp == OP_MULI || curOp == OP_ORI) ? immOperand : second_source_register;
	end

	// byte lane k=0 is the most significant byte
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_lane
			assign byteEq[k] = first_source_register[31-8*k -: 8]
				== second_source_register[31-8*k -: 8];
		end
	endgenerate

	always_comb begin
		bytePos = POS_NONE;
		for (int i = 3; i >= 0; i--) begin
			if (byteEq[i]) begin
				bytePos = POS_MSB + 3'(i);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// multiplier

	mopcu_mul_if mulBus ();
	mopcu_op_t   pendOp_reg, pendOp_next;

	always_comb begin
		mulBus.start = issue && !busy && isMul(curOp) && isBuilt(curOp);
		mulBus.opA = first_source_register;
		mulBus.opB = opBsel;
		unique case (curOp)
			OP_MULH:   mulBus.signMode = SIGN_SS;
			OP_MULHSU: mulBus.signMode = SIGN_SU;
			default:   mulBus.signMode = SIGN_UU;
		endcase
	end

	mopcu_multiplier #(
		.area_optimise_setting (area_optimise_setting)
	) u_mul (
		.clk   (clk),
		.rst_b (rst_b),
		.port  (mulBus.mul)
	);

	////////////////////////////////////////////////////////////////////////////////
	// result stage

	logic [REG_W-1:0]  pendDest_reg, pendDest_next;
	logic              busy_next;
	logic              resultValid_next;
	logic              writeEnable_next;
	logic              illegal_next;
	logic [REG_W-1:0]  destReg_next;
	logic [DATA_W-1:0] result_next;
	mopcu_op_t         doneOp;
	logic [REG_W-1:0]  doneDest;

	always_comb begin
		// fast build completes the request in its own issue cycle
		doneOp = (area_optimise_setting == AREA_SLOW) ? pendOp_reg : curOp;
		doneDest = (area_optimise_setting == AREA_SLOW) ? pendDest_reg : instrWord[25:21];
		busy_next = busy;
		pendOp_next = pendOp_reg;
		pendDest_next = pendDest_reg;
		resultValid_next = 1'b0;
		writeEnable_next = 1'b0;
		illegal_next = 1'b0;
		destReg_next = destReg;
		result_next = result;
		if (mulBus.done) begin
			busy_next = 1'b0;
			resultValid_next = 1'b1;
			writeEnable_next = 1'b1;
			destReg_next = doneDest;
			result_next = (doneOp == OP_MUL || doneOp == OP_MULI)
				? mulBus.product[DATA_W-1:0] : mulBus.product[PROD_W-1:DATA_W];
		end else if (issue && !busy) begin
			destReg_next = instrWord[25:21];
			if (!isBuilt(curOp)) begin
				resultValid_next = 1'b1;
				illegal_next = 1'b1;
			end else if (isMul(curOp)) begin
				pendOp_next = curOp;
				pendDest_next = instrWord[25:21];
				busy_next = (area_optimise_setting == AREA_SLOW);
			end else begin
				resultValid_next = 1'b1;
				writeEnable_next = 1'b1;
				unique case (curOp)
					OP_OR, OP_ORI: result_next = first_source_register | opBsel;
					OP_PCMPBF:     result_next = DATA_W'(bytePos);
					OP_PCMPEQ:     result_next = DATA_W'(first_source_register
						== second_source_register);
					OP_PCMPNE:     result_next = DATA_W'(first_source_register
						!= second_source_register);
					default:       result_next = result;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			busy <= 1'b0;
			pendOp_reg <= OP_NONE;
			pendDest_reg <= '0;
			resultValid <= 1'b0;
			writeEnable <= 1'b0;
			illegalInstr <= 1'b0;
			destReg <= '0;
			result <= '0;
		end else begin
			busy <= busy_next;
			pendOp_reg <= pendOp_next;
			pendDest_reg <= pendDest_next;
			resultValid <= resultValid_next;
			writeEnable <= writeEnable_next;
			illegalInstr <= illegal_next;
			destReg <= destReg_next;
			result <= result_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	logic [DATA_W-1:0] chkA, chkB;
	always_ff @(posedge clk) begin
		chkA <= first_source_register;
		chkB <= second_source_register;
	end

	property p_or_result;
		@(posedge clk) disable iff (!rst_b)
		(issue && !busy && curOp == OP_OR && isBuilt(OP_OR))
			|=> (writeEnable && result == (chkA | chkB));
	endproperty
	a_or_result: assert property (p_or_result) else $error("or result wrong");

	property p_eq_result;
		@(posedge clk) disable iff (!rst_b)
		(issue && !busy && curOp == OP_PCMPEQ && isBuilt(OP_PCMPEQ))
			|=> (result == DATA_W'(chkA == chkB));
	endproperty
	a_eq_result: assert property (p_eq_result) else $error("pcmpeq result wrong");

	property p_ne_result;
		@(posedge clk) disable iff (!rst_b)
		(issue && !busy && curOp == OP_PCMPNE && isBuilt(OP_PCMPNE))
			|=> (result == DATA_W'(chkA != chkB));
	endproperty
	a_ne_result: assert property (p_ne_result) else $error("pcmpne result wrong");

	property p_bf_range;
		@(posedge clk) disable iff (!rst_b)
		(issue && !busy && curOp == OP_PCMPBF && isBuilt(OP_PCMPBF))
			|=> (result <= 32'h4 && ((result == 32'h0) == (chkA[31:24] != chkB[31:24]
			&& chkA[23:16] != chkB[23:16] && chkA[15:8] != chkB[15:8] && chkA[7:0] != chkB[7:0])));
	endproperty
	a_bf_range: assert property (p_bf_range) else $error("pcmpbf result wrong");

	property p_bf_first;
		@(posedge clk) disable iff (!rst_b)
		(issue && !busy && curOp == OP_PCMPBF && isBuilt(OP_PCMPBF) && byteEq[0])
			|=> (result == 32'h1);
	endproperty
	a_bf_first: assert property (p_bf_first) else $error("pcmpbf msb not first");

	property p_mul_fast;
		@(posedge clk) disable iff (!rst_b)
		(mulBus.start && area_optimise_setting != AREA_SLOW) |=> (resultValid && writeEnable);
	endproperty
	a_mul_fast: assert property (p_mul_fast) else $error("fast multiply late");

	property p_mul_slow;
		@(posedge clk) disable iff (!rst_b)
		(mulBus.start && area_optimise_setting == AREA_SLOW)
			|=> (!resultValid && busy) ##1 (!resultValid && busy) ##1 (resultValid && !busy);
	endproperty
	a_mul_slow: assert property (p_mul_slow) else $error("slow multiply not three cycles");

	property p_mul_low;
		@(posedge clk) disable iff (!rst_b)
		(mulBus.start && curOp == OP_MUL && area_optimise_setting != AREA_SLOW)
			|=> (result == DATA_W'(chkA * chkB));
	endproperty
	a_mul_low: assert property (p_mul_low) else $error("mul low word wrong");

	property p_mulh_gate;
		@(posedge clk) disable iff (!rst_b)
		(issue && !busy && curOp == OP_MULH && hardware_multiplier_setting != HWMUL_WIDE)
			|=> (resultValid && illegalInstr && !writeEnable);
	endproperty
	a_mulh_gate: assert property (p_mulh_gate) else $error("mulh without wide product");
endmodule

// *** logic/mopcu_pkg.sv ***
// Purpose: shared constants and types for the multiply/OR/pattern-compare unit
// Assumes: instruction bit 0 is the word's most significant bit (big-endian numbering)
// Notes:   opcode field is bits 0..5, function field is bits 21..31
package mopcu_pkg;
	localparam int          DATA_W        = 32;
	localparam int          PROD_W        = 64;
	localparam int          IMM_W         = 16;
	localparam int          OPC_W         = 6;
	localparam int          FUNC_W        = 11;
	localparam int          REG_W         = 5;
	// major opcodes, bits 0..5
	localparam logic [5:0]  OPC_MUL       = 6'h10;
	localparam logic [5:0]  OPC_MULI      = 6'h18;
	localparam logic [5:0]  OPC_OR        = 6'h20;
	localparam logic [5:0]  OPC_ORI       = 6'h28;
	localparam logic [5:0]  OPC_PCMPBF    = 6'h20;
	localparam logic [5:0]  OPC_PCMPEQ    = 6'h22;
	localparam logic [5:0]  OPC_PCMPNE    = 6'h23;
	// function field values, bits 21..31
	localparam logic [10:0] FN_MUL        = 11'h000;
	localparam logic [10:0] FN_MULH       = 11'h001;
	localparam logic [10:0] FN_MULHSU     = 11'h002;
	localparam logic [10:0] FN_MULHU      = 11'h003;
	localparam logic [10:0] FN_OR         = 11'h000;
	localparam logic [10:0] FN_PCMP       = 11'h400;
	// build settings
	localparam int          AREA_SLOW     = 1;
	localparam int          HWMUL_WIDE    = 2;
	localparam logic [1:0]  SLOW_LAT_CNT  = 2'h2;
	// byte-find positions
	localparam logic [2:0]  POS_NONE      = 3'h0;
	localparam logic [2:0]  POS_MSB       = 3'h1;

	typedef enum logic [3:0] {
		OP_NONE, OP_MUL, OP_MULH, OP_MULHU, OP_MULHSU, OP_MULI,
		OP_OR, OP_ORI, OP_PCMPBF, OP_PCMPEQ, OP_PCMPNE
	} mopcu_op_t;

	typedef enum logic [1:0] {
		SIGN_UU, SIGN_SS, SIGN_SU
	} mopcu_sign_t;
endpackage

// *** logic/mopcu_mul_if.sv ***
// Purpose: carries a multiply request and its product between the top and the multiplier
// Assumes: one request at a time; start is a one-cycle pulse
// Notes:   fast build answers in the start cycle; slow build holds product until next start
interface mopcu_mul_if;
	import mopcu_pkg::*;
	logic                    start;
	logic [DATA_W-1:0]       opA;
	logic [DATA_W-1:0]       opB;
	mopcu_sign_t             signMode;
	logic                    done;
	logic [PROD_W-1:0]       product;
	modport req (output start, output opA, output opB, output signMode,
		input done, input product);
	modport mul (input start, input opA, input opB, input signMode,
		output done, output product);
endinterface

// *** logic/mopcu_multiplier.sv ***
// Purpose: 32x32 to 64-bit multiplier with signed, unsigned and mixed modes
// Assumes: synchronous active-low reset
// Notes:   slow build registers the product and holds it for two more cycles, a three-cycle total
module mopcu_multiplier #(
	parameter int area_optimise_setting = 0
) (
	input  wire logic clk,
	input  wire logic rst_b,
	mopcu_mul_if.mul  port
);
	import mopcu_pkg::*;

	logic signed [PROD_W:0] extA;
	logic signed [PROD_W:0] extB;
	logic        [PROD_W-1:0] prodNow;
	logic        [PROD_W-1:0] product_reg, product_next;
	logic        [1:0]        stage_reg, stage_next;

	// sign treatment per mode
	always_comb begin
		extA = {{(PROD_W-DATA_W+1){port.signMode != SIGN_UU && port.opA[DATA_W-1]}}, port.opA};
		extB = {{(PROD_W-DATA_W+1){port.signMode == SIGN_SS && port.opB[DATA_W-1]}}, port.opB};
		prodNow = PROD_W'(extA * extB);
	end

	always_comb begin
		product_next = product_reg;
		stage_next = stage_reg;
		if (port.start) begin
			product_next = prodNow;
			stage_next = SLOW_LAT_CNT;
		end else if (stage_reg != 2'h0) begin
			stage_next = stage_reg - 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			product_reg <= '0;
			stage_reg <= 2'h0;
		end else begin
			product_reg <= product_next;
			stage_reg <= stage_next;
		end
	end

	// fast build answers at once so the top registers the word in the issue cycle
	assign port.product = (area_optimise_setting == AREA_SLOW) ? product_reg : prodNow;
	// slow build: done in the last held cycle, result lands three cycles after issue
	assign port.done = (area_optimise_setting == AREA_SLOW) ? (stage_reg == 2'h1) : port.start;
endmodule

// *** test/mopcu_pipe_model.sv ***
// Purpose: pipeline side that issues decoded instructions to the unit
// Assumes: inputs change 1 ns after the rising edge; issue is a one-cycle pulse
// Notes:   operands are scrambled once released so stale values never look valid
module mopcu_pipe_model (
	input  wire logic                          clk,
	input  wire logic                          busy,
	output logic                               issue,
	output logic [mopcu_pkg::DATA_W-1:0]       instrWord,
	output logic [mopcu_pkg::DATA_W-1:0]       opA,
	output logic [mopcu_pkg::DATA_W-1:0]       opB,
	output logic                               prefixValid,
	output logic [mopcu_pkg::IMM_W-1:0]        prefixUpper
);
	timeunit 1ns;
	timeprecision 100ps;
	import mopcu_pkg::*;

	initial begin
		issue = 1'b0;
		instrWord = 32'h00000000;
		opA = 32'h00000000;
		opB = 32'h00000000;
		prefixValid = 1'b0;
		prefixUpper = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one issue pulse; waits for busy low unless told to push into a busy unit
	task automatic send(input logic [5:0] opc, input logic [4:0] rd, input logic [15:0] low,
		input logic [31:0] a, input logic [31:0] b, input logic pv, input logic [15:0] pu,
		input bit noWait);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		while (busy === 1'b1 && !noWait && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		issue = 1'b1;
		instrWord = {opc, rd, 5'h01, low};
		opA = a;
		opB = b;
		prefixValid = pv;
		prefixUpper = pu;
		@(posedge clk);
		#1;
		issue = 1'b0;
		instrWord = ~instrWord;
		opA = ~opA;
		opB = ~opB;
		prefixValid = 1'b0;
		prefixUpper = ~prefixUpper;
	endtask
endmodule

// *** test/mopcu_top_test.sv ***
// Purpose: self-checking bench for fast, slow and reduced builds side by side
// Assumes: all three builds see the same issued instruction
// Notes:   index 0 fast full, 1 area-optimised, 2 no wide product and no compares
module mopcu_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	import mopcu_pkg::*;

	localparam int AREA[3] = '{0, 1, 0};
	localparam int HWM[3]  = '{2, 2, 1};
	localparam int PCE[3]  = '{1, 1, 0};

	logic        clk;
	logic        rst_b;
	logic        issue;
	logic        pv;
	logic [31:0] iw;
	logic [31:0] a;
	logic [31:0] b;
	logic [15:0] pu;
	logic        rv[3];
	logic        we[3];
	logic        il[3];
	logic        bz[3];
	logic [4:0]  dr[3];
	logic [31:0] rs[3];
	int          fails;
	int          cmpCount;

	initial clk = 1'b0;
	always #20 clk = ~clk;

	mopcu_pipe_model i_pipe (.clk(clk), .busy(bz[1]), .issue(issue), .instrWord(iw), .opA(a),
		.opB(b), .prefixValid(pv), .prefixUpper(pu));

	for (genvar k = 0; k < 3; k++) begin : g_dut
		mopcu_top #(.area_optimise_setting(AREA[k]), .hardware_multiplier_setting(HWM[k]),
			.pattern_compare_enable(PCE[k])) i_dut (.clk(clk), .rst_b(rst_b), .issue(issue),
			.instrWord(iw), .first_source_register(a), .second_source_register(b),
			.prefixValid(pv), .prefixUpper(pu), .resultValid(rv[k]), .writeEnable(we[k]),
			.destReg(dr[k]), .result(rs[k]), .illegalInstr(il[k]), .busy(bz[k]));
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (fails == 0 && cmpCount > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// register multiplies: function bits 30,31 pick the variant
	function automatic logic [16:0] enc(mopcu_op_t op);
		case (op)
			OP_MUL:    return {OPC_MUL, FN_MUL};
			OP_MULH:   return {OPC_MUL, FN_MULH};
			OP_MULHU:  return {OPC_MUL, FN_MULHU};
			OP_MULHSU: return {OPC_MUL, FN_MULHSU};
			OP_MULI:   return {OPC_MULI, 11'h000};
			OP_OR:     return {OPC_OR, FN_OR};
			OP_ORI:    return {OPC_ORI, 11'h000};
			OP_PCMPBF: return {OPC_PCMPBF, FN_PCMP};
			OP_PCMPEQ: return {OPC_PCMPEQ, FN_PCMP};
			OP_PCMPNE: return {OPC_PCMPNE, FN_PCMP};
			default:   return {OPC_MUL, 11'h004};
		endcase
	endfunction

	function automatic logic [31:0] expv(mopcu_op_t op, logic [31:0] x, logic [31:0] y,
		logic [31:0] m);
		logic [63:0] p;
		p = 64'h0;
		case (op)
			OP_MUL:    p = x * y;
			OP_MULH:   p = {{32{x[31]}}, x} * {{32{y[31]}}, y};
			OP_MULHU:  p = {32'h0, x} * {32'h0, y};
			OP_MULHSU: p = {{32{x[31]}}, x} * {32'h0, y};
			OP_MULI:   p = x * m;
			OP_OR:     return x | y;
			OP_ORI:    return x | m;
			OP_PCMPEQ: return {31'h0, x == y};
			OP_PCMPNE: return {31'h0, x != y};
			OP_PCMPBF: begin
				for (int i = 0; i < 4; i++) begin
					if (x[31 - 8 * i -: 8] == y[31 - 8 * i -: 8]) return 32'(i + 1);
				end
				return 32'h0;
			end
			default:   p = 64'h0;
		endcase
		return (op inside {OP_MUL, OP_MULI}) ? p[31:0] : p[63:32];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic outs(int k, mopcu_op_t op, logic [31:0] e, logic [4:0] rd);
		bit ok;
		ok = op != OP_NONE && !(k == 2 && op inside {OP_MULH, OP_MULHU, OP_MULHSU, OP_PCMPBF,
			OP_PCMPEQ, OP_PCMPNE});
		check($sformatf("resultValid%0d", k), rv[k], 1'b1);
		check($sformatf("writeEnable%0d", k), we[k], ok);
		check($sformatf("illegalInstr%0d", k), il[k], !ok);
		if (ok) begin
			check($sformatf("result%0d", k), rs[k], e);
			check($sformatf("destReg%0d", k), dr[k], rd);
		end
	endtask

	task automatic run(mopcu_op_t op, logic [31:0] x, logic [31:0] y, logic [15:0] im,
		logic pvv, logic [15:0] puv, logic [4:0] rd);
		logic [16:0] c;
		logic [31:0] e;
		bit          slow;
		c = enc(op);
		// prefix supplies the upper half, else sign-extend
		e = expv(op, x, y, pvv ? {puv, im} : {{16{im[15]}}, im});
		slow = op inside {OP_MUL, OP_MULH, OP_MULHU, OP_MULHSU, OP_MULI};
		i_pipe.send(c[16:11], rd, (op inside {OP_MULI, OP_ORI}) ? im : {5'h02, c[10:0]},
			x, y, pvv, puv, 0);
		outs(0, op, e, rd);
		outs(2, op, e, rd);
		if (!slow) outs(1, op, e, rd);
		if (slow) begin
			check("busy", bz[1], 1'b1);
			check("earlyValid", rv[1], 1'b0);
			repeat (2) @(posedge clk);
			#1;
			outs(1, op, e, rd);
			check("busyEnd", bz[1], 1'b0);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_mul();
		mopcu_op_t   ops[4] = '{OP_MUL, OP_MULH, OP_MULHU, OP_MULHSU};
		logic [31:0] xs[3] = '{32'hFFFFFFFE, 32'h80000000, 32'h12345678};
		logic [31:0] ys[3] = '{32'h00000003, 32'h80000000, 32'h9ABCDEF0};
		foreach (ops[i]) begin
			foreach (xs[j]) run(ops[i], xs[j], ys[j], 16'h0000, 1'b0, 16'h0000, 5'h07);
		end
	endtask

	task automatic t_imm();
		run(OP_MULI, 32'h00000007, 32'h0, 16'hFFFD, 1'b0, 16'h0000, 5'h03);
		run(OP_MULI, 32'h00000003, 32'h0, 16'h0002, 1'b1, 16'h0001, 5'h04);
		run(OP_ORI, 32'h00000100, 32'h0, 16'h8001, 1'b0, 16'h0000, 5'h05);
		run(OP_ORI, 32'h00000100, 32'h0, 16'h8001, 1'b1, 16'h0000, 5'h06);
	endtask

	task automatic t_or();
		run(OP_OR, 32'hF0F00000, 32'h0000F0F0, 16'h0000, 1'b0, 16'h0000, 5'h1F);
		run(OP_OR, 32'h00000000, 32'h00000000, 16'h0000, 1'b0, 16'h0000, 5'h00);
	endtask

	task automatic t_pcmp();
		logic [31:0] ys[6] = '{32'h11000000, 32'h00220000, 32'h00003300, 32'h00000044,
			32'h55667788, 32'h11223344};
		foreach (ys[i]) run(OP_PCMPBF, 32'h11223344, ys[i], 16'h0, 1'b0, 16'h0, 5'h02);
		run(OP_PCMPEQ, 32'h11223344, 32'h11223344, 16'h0, 1'b0, 16'h0, 5'h08);
		run(OP_PCMPEQ, 32'h11223344, 32'h11223345, 16'h0, 1'b0, 16'h0, 5'h08);
		run(OP_PCMPNE, 32'h11223344, 32'h11223344, 16'h0, 1'b0, 16'h0, 5'h09);
		run(OP_PCMPNE, 32'h11223344, 32'h11223345, 16'h0, 1'b0, 16'h0, 5'h09);
	endtask

	// issue into a busy slow unit must be dropped, then an unknown function
	task automatic t_refuse();
		i_pipe.send(OPC_MUL, 5'h0A, {5'h02, FN_MUL}, 32'h5, 32'h6, 1'b0, 16'h0, 0);
		i_pipe.send(OPC_OR, 5'h0B, {5'h02, FN_OR}, 32'h1, 32'h2, 1'b0, 16'h0, 1);
		check("slowDone", rv[1], 1'b1);
		check("slowResult", rs[1], 32'h0000001E);
		check("fastOr", rs[0], 32'h00000003);
		@(posedge clk);
		#1;
		check("dropped", rv[1], 1'b0);
		run(OP_NONE, 32'h5, 32'h6, 16'h0, 1'b0, 16'h0, 5'h0C);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		fails = 0;
		cmpCount = 0;
		rst_b = 1'b0;
		repeat (16) @(posedge clk);
		#1;
		for (int k = 0; k < 3; k++) begin
			check("resetValid", rv[k], 1'b0);
			check("resetResult", rs[k], 32'h0);
		end
		rst_b = 1'b1;
		t_mul();
		t_imm();
		t_or();
		t_pcmp();
		t_refuse();
		finish_test();
	end

	initial begin
		#(40 * 3000);
		fails++;
		finish_test();
	end
endmodule
